// ==== design/flc_ctrl.sv ====
// Flash command sequencer: register port, command sequences and bit-7 status polling.
`timescale 1ns/10ps
`include "flc_map.svh"
module flc_ctrl
    import flc_pkg::*;
#(
    parameter logic [23:0] POLL_LIMIT = 24'hFFFFFF
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Software register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Flash pins.
    output logic [19:0] fl_addr,
    output logic [15:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_i,
    output logic fl_ce_n,
    output logic fl_we_n,
    output logic fl_oe_n,
    output logic fl_byte_n
);
    typedef struct packed {
        flc_state_t st;
        flc_op_t op;
        logic [2:0] idx;
        logic last;
        logic [19:0] addr;
        logic [15:0] wdata;
        logic bm;
        logic byte_n;
        logic done;
        logic fail;
        logic refused;
        logic byp;
        logic ids;
        logic susp;
        logic epend;
        logic echip;
        logic exp7;
        logic [10:0] win;
        logic [8:0] scnt;
        logic [23:0] pcnt;
        logic [15:0] rdata;
        logic go;
        logic erd;
        logic [19:0] ea;
        logic [15:0] ed;
        logic [31:0] rdout;
    } flc_st_t;

    flc_st_t s_r, s_nxt;
    logic e_done;
    logic [15:0] e_rdata;
    flc_step_t step;

    // Bus address and data of cycle i of an operation.
    function automatic flc_step_t flc_step(flc_op_t op, logic [2:0] i, logic bm,
            logic [19:0] a, logic [15:0] d);
        logic [19:0] u1;
        logic [19:0] u2;
        flc_step_t s;
        u1 = bm ? `FLC_U1_BYTE : `FLC_U1_WORD;
        u2 = bm ? `FLC_U2_BYTE : `FLC_U2_WORD;
        s = '{rd: 1'b0, last: 1'b0, a: u1, d: `FLC_D_UNLK1};
        if (i == 3'h1 || i == 3'h4) begin
            s.a = u2;
            s.d = `FLC_D_UNLK2;
        end
        case (op)
            OP_RESET: s = '{rd: 1'b0, last: 1'b1, a: `FLC_ANY_ADDR, d: `FLC_D_RESET};
            OP_AUTOSEL: begin
                if (i == 3'h2) s.d = `FLC_D_IDENT;
                // Fourth cycle is a read at the code or sector address.
                if (i == 3'h3) s = '{rd: 1'b1, last: 1'b1, a: a, d: 16'h0000};
            end
            OP_PROGRAM: begin
                if (i == 3'h2) s.d = `FLC_D_PROG;
                if (i == 3'h3) s = '{rd: 1'b0, last: 1'b1, a: a, d: d};
            end
            OP_BYP_ENTER: begin
                if (i == 3'h2) s = '{rd: 1'b0, last: 1'b1, a: u1, d: `FLC_D_BYPASS};
            end
            OP_BYP_PROG: begin
                s = (i == 3'h0) ? '{rd: 1'b0, last: 1'b0, a: `FLC_ANY_ADDR, d: `FLC_D_PROG}
                    : '{rd: 1'b0, last: 1'b1, a: a, d: d};
            end
            OP_BYP_EXIT: begin
                s = '{rd: 1'b0, last: i != 3'h0, a: `FLC_ANY_ADDR,
                    d: (i == 3'h0) ? `FLC_D_IDENT : `FLC_D_BYP_EXIT2};
            end
            OP_CHIP_ERASE, OP_SECT_ERASE: begin
                if (i == 3'h2) s.d = `FLC_D_ERASE_SET;
                if (i == 3'h5) begin
                    s.last = 1'b1;
                    s.a = (op == OP_CHIP_ERASE) ? u1 : a;
                    s.d = (op == OP_CHIP_ERASE) ? `FLC_D_CHIP : `FLC_D_SECTOR;
                end
            end
            OP_SECT_ADD: s = '{rd: 1'b0, last: 1'b1, a: a, d: `FLC_D_SECTOR};
            OP_SUSPEND: s = '{rd: 1'b0, last: 1'b1, a: `FLC_ANY_ADDR, d: `FLC_D_SUSPEND};
            OP_RESUME: s = '{rd: 1'b0, last: 1'b1, a: `FLC_ANY_ADDR, d: `FLC_D_RESUME};
            default: s = '{rd: 1'b1, last: 1'b1, a: a, d: 16'h0000};
        endcase
        return s;
    endfunction : flc_step

    // Whether an operation is legal in the device mode the sequencer tracks.
    function automatic logic flc_ok(flc_op_t op, flc_st_t s);
        logic plain;
        plain = !s.byp && !s.ids && !(s.epend && !s.susp);
        case (op)
            OP_READ: flc_ok = !s.ids && !(s.epend && !s.susp);
            OP_RESET: flc_ok = !s.byp && !(s.epend && !s.susp);
            OP_AUTOSEL, OP_PROGRAM: flc_ok = plain;
            OP_BYP_ENTER, OP_CHIP_ERASE, OP_SECT_ERASE: flc_ok = plain && !s.susp;
            OP_BYP_PROG, OP_BYP_EXIT: flc_ok = s.byp;
            OP_SECT_ADD: flc_ok = s.win != 11'h000;
            OP_SUSPEND: flc_ok = s.epend && !s.echip && !s.susp;
            OP_RESUME: flc_ok = s.susp && !s.ids;
            OP_POLL_ERASE: flc_ok = s.epend && !s.susp;
            default: flc_ok = 1'b0;
        endcase
    endfunction : flc_ok

    assign step = flc_step(s_r.op, s_r.idx, s_r.bm, s_r.addr, s_r.wdata);

    // Register port, sequencing, polling and mode tracking.
    always_comb begin
        s_nxt = s_r;
        s_nxt.go = 1'b0;
        s_nxt.rdout = 32'h00000000;
        if (s_r.win != 11'h000) s_nxt.win = s_r.win - 11'h001;
        if (reg_wr) begin
            case (reg_addr)
                `FLC_REG_ADDR: s_nxt.addr = reg_wdata[`FLC_ADDR_F];
                `FLC_REG_WDATA: s_nxt.wdata = reg_wdata[`FLC_DATA_F];
                `FLC_REG_CFG: if (s_r.st == ST_IDLE) s_nxt.bm = reg_wdata[`FLC_CFG_BYTE];
                `FLC_REG_CTRL: begin
                    // A busy sequencer or an illegal order is refused, so no
                    // partial or mismatching sequence ever reaches the device.
                    if (s_r.st == ST_IDLE && flc_ok(flc_op_t'(reg_wdata[`FLC_CTRL_OP]), s_r)) begin
                        s_nxt.op = flc_op_t'(reg_wdata[`FLC_CTRL_OP]);
                        s_nxt.idx = 3'h0;
                        s_nxt.done = 1'b0;
                        s_nxt.fail = 1'b0;
                        s_nxt.refused = 1'b0;
                        s_nxt.pcnt = 24'h000000;
                        s_nxt.exp7 = 1'b1;
                        s_nxt.st = (flc_op_t'(reg_wdata[`FLC_CTRL_OP]) == OP_POLL_ERASE)
                            ? ST_POLL : ST_ISSUE;
                    end else begin
                        s_nxt.refused = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // The width pin is registered so it never glitches while the mode flips.
        s_nxt.byte_n = ~s_nxt.bm;
        if (reg_rd) begin
            case (reg_addr)
                `FLC_REG_ADDR: s_nxt.rdout = {12'h000, s_r.addr};
                `FLC_REG_WDATA: s_nxt.rdout = {16'h0000, s_r.wdata};
                `FLC_REG_CFG: s_nxt.rdout = {31'h00000000, s_r.bm};
                `FLC_REG_RDATA: s_nxt.rdout = {16'h0000, s_r.rdata};
                `FLC_REG_STATUS: s_nxt.rdout = 32'(flc_status_t'{zero: 23'h000000,
                    win: s_r.win != 11'h000, epend: s_r.epend, susp: s_r.susp,
                    ids: s_r.ids, byp: s_r.byp, refused: s_r.refused, fail: s_r.fail,
                    done: s_r.done, busy: s_r.st != ST_IDLE});
                default: s_nxt.rdout = 32'h00000000;
            endcase
        end
        case (s_r.st)
            ST_IDLE: ;
            ST_ISSUE: begin
                s_nxt.go = 1'b1;
                s_nxt.erd = step.rd;
                s_nxt.ea = step.a;
                s_nxt.ed = step.d;
                s_nxt.last = step.last;
                s_nxt.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (e_done) begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.done = 1'b1;
                    if (!s_r.last) begin
                        s_nxt.idx = s_r.idx + 3'h1;
                        s_nxt.st = ST_ISSUE;
                        s_nxt.done = 1'b0;
                    end else begin
                        case (s_r.op)
                            OP_READ: s_nxt.rdata = e_rdata;
                            OP_AUTOSEL: begin
                                s_nxt.rdata = e_rdata;
                                s_nxt.ids = 1'b1;
                            end
                            OP_RESET: s_nxt.ids = 1'b0;
                            OP_PROGRAM, OP_BYP_PROG: begin
                                // Status is read only after the final strobe rose.
                                s_nxt.exp7 = s_r.wdata[7];
                                s_nxt.st = ST_POLL;
                                s_nxt.done = 1'b0;
                            end
                            OP_BYP_ENTER: s_nxt.byp = 1'b1;
                            OP_BYP_EXIT: s_nxt.byp = 1'b0;
                            OP_CHIP_ERASE: begin
                                s_nxt.epend = 1'b1;
                                s_nxt.echip = 1'b1;
                                s_nxt.win = 11'h000;
                            end
                            OP_SECT_ERASE, OP_SECT_ADD: begin
                                s_nxt.epend = 1'b1;
                                s_nxt.echip = 1'b0;
                                s_nxt.win = 11'(`FLC_WIN_CYC);
                            end
                            OP_SUSPEND: begin
                                // Inside the window the device suspends at once.
                                if (s_r.win != 11'h000) begin
                                    s_nxt.susp = 1'b1;
                                    s_nxt.win = 11'h000;
                                end else begin
                                    s_nxt.scnt = 9'(`FLC_SUSP_CYC);
                                    s_nxt.st = ST_SUSP;
                                    s_nxt.done = 1'b0;
                                end
                            end
                            OP_RESUME: s_nxt.susp = 1'b0;
                            default: ;
                        endcase
                    end
                end
            end
            ST_POLL: begin
                s_nxt.go = 1'b1;
                s_nxt.erd = 1'b1;
                s_nxt.ea = s_r.addr;
                s_nxt.st = ST_PWAIT;
            end
            ST_PWAIT: begin
                if (e_done) begin
                    if (e_rdata[7] == s_r.exp7) begin
                        s_nxt.st = ST_FINAL;
                    end else if (s_r.pcnt == POLL_LIMIT) begin
                        // A stuck operation is abandoned with a reset write.
                        s_nxt.fail = 1'b1;
                        s_nxt.epend = 1'b0;
                        s_nxt.op = OP_RESET;
                        s_nxt.idx = 3'h0;
                        s_nxt.st = ST_ISSUE;
                    end else begin
                        s_nxt.pcnt = s_r.pcnt + 24'h000001;
                        s_nxt.st = ST_POLL;
                    end
                end
            end
            ST_FINAL: begin
                // Bit 7 may flip ahead of the rest, so the data come from a new read.
                s_nxt.go = 1'b1;
                s_nxt.erd = 1'b1;
                s_nxt.ea = s_r.addr;
                s_nxt.st = ST_FWAIT;
            end
            ST_FWAIT: begin
                if (e_done) begin
                    s_nxt.rdata = e_rdata;
                    s_nxt.done = 1'b1;
                    if (s_r.op == OP_POLL_ERASE) s_nxt.epend = 1'b0;
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_SUSP: begin
                if (s_r.scnt == 9'h000) begin
                    s_nxt.susp = 1'b1;
                    s_nxt.done = 1'b1;
                    s_nxt.st = ST_IDLE;
                end else begin
                    s_nxt.scnt = s_r.scnt - 9'h001;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '{st: ST_IDLE, op: OP_READ, byte_n: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Bus cycle engine on the flash pins.
    flc_cycle u_cycle (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(s_r.go),
        .rd(s_r.erd),
        .addr(s_r.ea),
        .wdata(s_r.ed),
        .done(e_done),
        .rdata(e_rdata),
        .fl_addr(fl_addr),
        .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe),
        .fl_dq_i(fl_dq_i),
        .fl_ce_n(fl_ce_n),
        .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n)
    );

    assign reg_rdata = s_r.rdout;
    assign fl_byte_n = s_r.byte_n;

endmodule : flc_ctrl

// ==== design/flc_map.svh ====
// Register offsets, fields, flash command codes and timing constants of the flash controller.
`ifndef FLC_MAP_SVH
`define FLC_MAP_SVH

// Register byte offsets on the software port.
`define FLC_REG_CTRL 8'h00
`define FLC_REG_ADDR 8'h04
`define FLC_REG_WDATA 8'h08
`define FLC_REG_STATUS 8'h0C
`define FLC_REG_CFG 8'h10
`define FLC_REG_RDATA 8'h14

// Register fields.
`define FLC_CTRL_OP 3:0
`define FLC_ADDR_F 19:0
`define FLC_DATA_F 15:0
`define FLC_CFG_BYTE 0

// Unlock addresses for word and byte bus width.
`define FLC_U1_WORD 20'h00555
`define FLC_U2_WORD 20'h002AA
`define FLC_U1_BYTE 20'h00AAA
`define FLC_U2_BYTE 20'h00555
`define FLC_ANY_ADDR 20'h00000

// Command codes, low byte only; the high byte is driven as zero.
`define FLC_D_UNLK1 16'h00AA
`define FLC_D_UNLK2 16'h0055
`define FLC_D_RESET 16'h00F0
`define FLC_D_IDENT 16'h0090
`define FLC_D_PROG 16'h00A0
`define FLC_D_BYPASS 16'h0020
`define FLC_D_BYP_EXIT2 16'h0000
`define FLC_D_ERASE_SET 16'h0080
`define FLC_D_CHIP 16'h0010
`define FLC_D_SECTOR 16'h0030
`define FLC_D_SUSPEND 16'h00B0
`define FLC_D_RESUME 16'h0030

// Timing: figures in their own unit, cycle counts derived at 40 ns per clock.
`define FLC_CLK_NS 40
`define FLC_T_WP_NS 35
`define FLC_T_ACC_NS 70
`define FLC_SYNC_STAGES 2
`define FLC_WP_CYC ((`FLC_T_WP_NS + `FLC_CLK_NS - 1) / `FLC_CLK_NS)
`define FLC_RD_CYC (((`FLC_T_ACC_NS + `FLC_CLK_NS - 1) / `FLC_CLK_NS) + `FLC_SYNC_STAGES)
`define FLC_T_SUSP_US 20
`define FLC_SUSP_CYC ((`FLC_T_SUSP_US * 1000 + `FLC_CLK_NS - 1) / `FLC_CLK_NS)
`define FLC_T_WIN_US 50
`define FLC_WIN_CYC ((`FLC_T_WIN_US * 1000) / `FLC_CLK_NS)

`endif

// ==== design/flc_pkg.sv ====
// Types shared by the flash controller and its bus cycle engine.
package flc_pkg;

    // Operations that software orders through the control register.
    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_RESET = 4'h1, OP_AUTOSEL = 4'h2, OP_PROGRAM = 4'h3,
        OP_BYP_ENTER = 4'h4, OP_BYP_PROG = 4'h5, OP_BYP_EXIT = 4'h6,
        OP_CHIP_ERASE = 4'h7, OP_SECT_ERASE = 4'h8, OP_SECT_ADD = 4'h9,
        OP_SUSPEND = 4'hA, OP_RESUME = 4'hB, OP_POLL_ERASE = 4'hC
    } flc_op_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_ISSUE = 3'b001, ST_WAIT = 3'b010, ST_POLL = 3'b011,
        ST_PWAIT = 3'b100, ST_FINAL = 3'b101, ST_FWAIT = 3'b110, ST_SUSP = 3'b111
    } flc_state_t;

    // Bus cycle phases.
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00, PH_SETUP = 2'b01, PH_STRB = 2'b10, PH_REC = 2'b11
    } flc_phase_t;

    // One bus cycle of a command sequence.
    typedef struct packed {
        logic rd;
        logic last;
        logic [19:0] a;
        logic [15:0] d;
    } flc_step_t;

    // Status register layout, bit 0 at the bottom.
    typedef struct packed {
        logic [22:0] zero;
        logic win;
        logic epend;
        logic susp;
        logic ids;
        logic byp;
        logic refused;
        logic fail;
        logic done;
        logic busy;
    } flc_status_t;

    // Bus cycle engine state.
    typedef struct packed {
        flc_phase_t ph;
        logic [2:0] cnt;
        logic rd;
        logic [19:0] addr;
        logic [15:0] dout;
        logic dq_oe;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] rdata;
        logic done;
    } flc_cyc_st_t;

    localparam flc_cyc_st_t FLC_CYC_RST = '{ph: PH_IDLE, ce_n: 1'b1, we_n: 1'b1,
        oe_n: 1'b1, default: '0};

endpackage : flc_pkg

// ==== design/flc_cycle.sv ====
// Bus cycle engine: one write or one read cycle on the flash pins.
`timescale 1ns/10ps
`include "flc_map.svh"
module flc_cycle
    import flc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Cycle request and answer.
    input wire logic start,
    input wire logic rd,
    input wire logic [19:0] addr,
    input wire logic [15:0] wdata,
    output logic done,
    output logic [15:0] rdata,
    // Flash pins.
    output logic [19:0] fl_addr,
    output logic [15:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_i,
    output logic fl_ce_n,
    output logic fl_we_n,
    output logic fl_oe_n
);
    flc_cyc_st_t s_r, s_nxt;

    // Address and chip select settle one cycle before the strobe falls, so the
    // device latches a stable address on the later falling edge.
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.sync1 = fl_dq_i;
        s_nxt.sync2 = s_r.sync1;
        case (s_r.ph)
            PH_IDLE: begin
                if (start) begin
                    s_nxt.ph = PH_SETUP;
                    s_nxt.rd = rd;
                    s_nxt.addr = addr;
                    s_nxt.dout = wdata;
                    s_nxt.ce_n = 1'b0;
                    s_nxt.dq_oe = ~rd;
                end
            end
            PH_SETUP: begin
                s_nxt.ph = PH_STRB;
                s_nxt.we_n = s_r.rd;
                s_nxt.oe_n = ~s_r.rd;
                s_nxt.cnt = s_r.rd ? 3'(`FLC_RD_CYC - 1) : 3'(`FLC_WP_CYC - 1);
            end
            PH_STRB: begin
                if (s_r.cnt == 3'h0) begin
                    // Strobe and select rise together while data is still driven.
                    s_nxt.we_n = 1'b1;
                    s_nxt.ce_n = 1'b1;
                    s_nxt.oe_n = 1'b1;
                    s_nxt.ph = PH_REC;
                    if (s_r.rd) begin
                        s_nxt.rdata = s_r.sync2;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 3'h1;
                end
            end
            PH_REC: begin
                s_nxt.dq_oe = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.ph = PH_IDLE;
            end
            default: s_nxt.ph = PH_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= FLC_CYC_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Every pin comes straight from the state register.
    assign done = s_r.done;
    assign rdata = s_r.rdata;
    assign fl_addr = s_r.addr;
    assign fl_dq_o = s_r.dout;
    assign fl_dq_oe = s_r.dq_oe;
    assign fl_ce_n = s_r.ce_n;
    assign fl_we_n = s_r.we_n;
    assign fl_oe_n = s_r.oe_n;

endmodule : flc_cycle

// ==== bench/flc_flash_model.sv ====
// Behavioural flash device: command decode, small array and bit-7 polling.
`timescale 1ns/10ps
module flc_flash_model (
    // Device pins.
    input wire logic [19:0] a,
    input wire logic [15:0] d,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic slow,
    output logic [15:0] q
);
    logic [15:0] mem [0:255];
    logic [19:0] la;
    logic byp = 1'b0;
    logic [7:0] c;
    int stg = 0;
    int busy = 0;
    // The array starts erased.
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    initial q = 16'h0000;
    // Address is taken as the later strobe falls.
    always @(negedge we_n) if (!ce_n) la = a;
    // Data is taken as the first strobe rises; only the low byte decodes.
    always @(posedge we_n) begin
        c = d[7:0];
        if (stg == 3) begin
            mem[la[7:0]] = d;
            busy = slow ? 40 : 3;
            stg = 0;
        end else if (stg == 4) begin
            byp = (c != 8'h00);
            stg = 0;
        end else if (byp) stg = (c == 8'hA0) ? 3 : (c == 8'h90) ? 4 : 0;
        else if (c == 8'hF0) begin
            // A reset write abandons a running program.
            stg = 0;
            busy = 0;
        end
        else if (stg == 0 && c == 8'hAA && la[10:0] == 11'h555) stg = 1;
        else if (stg == 1 && c == 8'h55 && la[10:0] == 11'h2AA) stg = 2;
        else if (stg == 2 && c == 8'h20) begin
            byp = 1'b1;
            stg = 0;
        end else stg = (stg == 2 && c == 8'hA0) ? 3 : 0;
    end
    // A busy program reads back bit 7 inverted; slow mode outlasts the poll limit.
    always @(negedge oe_n) q = (busy > 0) ? mem[a[7:0]] ^ 16'h0080 : mem[a[7:0]];
    // Released pins show the inverse of the last value, never a kind constant.
    always @(posedge oe_n) begin
        q = ~q;
        if (busy > 0) busy--;
    end
endmodule : flc_flash_model

// ==== bench/flc_ctrl_properties.sv ====
// Pin and register port checks on the flash controller.
`timescale 1ns/10ps
module flc_ctrl_properties (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Register read port.
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Flash pins.
    input wire logic [19:0] fl_addr,
    input wire logic [15:0] fl_dq_o,
    input wire logic fl_dq_oe,
    input wire logic fl_ce_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    input wire logic fl_byte_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_ce_gates: assert property (fl_ce_n |-> fl_we_n && fl_oe_n)
        else $error("strobe without chip select");
    chk_ce_first: assert property ($fell(fl_we_n) |-> !$past(fl_ce_n))
        else $error("chip select late");
    chk_read_only: assert property (!fl_oe_n |-> fl_we_n && !fl_dq_oe)
        else $error("read overlaps a write");
    chk_dq_driven: assert property (!fl_we_n |-> fl_dq_oe)
        else $error("write strobe without data");
    chk_we_pulse: assert property ($fell(fl_we_n) |=> fl_we_n)
        else $error("write strobe too long");
    chk_latch_hold: assert property ($rose(fl_we_n) |-> $stable(fl_dq_o) && $stable(fl_addr))
        else $error("address or data moved at strobe rise");
    chk_dq_release: assert property ($rose(fl_we_n) |=> !fl_dq_oe)
        else $error("data pins held too long");
    chk_oe_length: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*4] ##1 fl_oe_n && fl_ce_n)
        else $error("read strobe length wrong");
    chk_rdata_slot: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
        else $error("read data outside its slot");
    chk_width_steady: assert property (!fl_ce_n |-> $stable(fl_byte_n))
        else $error("bus width changed inside a cycle");
    // The main scenarios: writes, reads and a failed poll.
    cover property ($fell(fl_we_n));
    cover property ($fell(fl_oe_n));
    cover property (reg_rdata[2]);
endmodule : flc_ctrl_properties
bind flc_ctrl flc_ctrl_properties flc_ctrl_properties_i (.sys_clk(sys_clk), .resetn(resetn),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_byte_n(fl_byte_n));

// ==== bench/flc_ctrl_tb.sv ====
// Self-checking bench: the controller drives a behavioural flash device.
`timescale 1ns/10ps
module flc_ctrl_tb
    import flc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic slow = 1'b0;
    logic [31:0] reg_rdata;
    logic [19:0] fl_addr;
    logic [15:0] fl_dq_o, fl_dq_i, w;
    logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n;
    logic [31:0] qe[$], qm[$];
    int n_errors = 0;
    int comparisons = 0;
    flc_ctrl #(.POLL_LIMIT(24'h000010)) flc_ctrl_i (.sys_clk(sys_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
        .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
        .fl_byte_n());
    flc_flash_model flc_flash_model_i (.a(fl_addr), .d(fl_dq_o), .ce_n(fl_ce_n),
        .we_n(fl_we_n), .oe_n(fl_oe_n), .slow(slow), .q(fl_dq_i));
    // Free-running 25 MHz clock.
    initial forever #20 sys_clk = ~sys_clk;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // A zero mask marks a read whose result is not compared.
    task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        qe.push_back(e);
        qm.push_back(m);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask : chk
    // Polls busy with a bound, so a stuck sequencer counts as a mismatch.
    task automatic op(input flc_op_t o);
        wr(8'h00, {28'h0, o});
        for (int i = 0; i < 300; i++) begin
            chk(8'h0C, 32'h0, 32'h0);
            @(negedge sys_clk);
            if (reg_rdata[0] === 1'b0) return;
        end
        n_errors++;
        $display("CHECK FAILED %0t busy stuck", $time);
    endtask : op
    task automatic results();
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    // Read data is compared in the one cycle after its strobe.
    always @(posedge sys_clk) begin
        rd_d <= reg_rd;
        if (rd_d && qm.size() > 0) begin
            if (qm[0] != 32'h0) begin
                comparisons++;
                if ((reg_rdata & qm[0]) !== (qe[0] & qm[0])) begin
                    n_errors++;
                    $display("CHECK FAILED %0t read %h", $time, reg_rdata);
                end
            end
            void'(qm.pop_front());
            void'(qe.pop_front());
        end
    end
    // Watchdog: the whole run needs well under a tenth of this span.
    initial begin
        #(40 * 30000);
        n_errors++;
        results();
    end
    initial begin
        w = 16'($urandom(32'hA50F4ABC));
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        chk(8'h0C, 32'h0, 32'hFFFFFFFF);
        chk(8'h20, 32'h0, 32'hFFFFFFFF);
        $display("reset test done");
        // Program with upper address bits set, then read back as plain array data.
        for (int i = 0; i < 3; i++) begin
            w = 16'($urandom);
            wr(8'h04, {12'h0, 20'h7F000 | 20'($urandom_range(127))});
            wr(8'h08, {16'h0, w});
            op(OP_PROGRAM);
            chk(8'h0C, 32'h2, 32'hF);
            chk(8'h14, {16'h0, w}, 32'hFFFF);
            op(OP_READ);
            chk(8'h14, {16'h0, w}, 32'hFFFF);
        end
        $display("program test done");
        op(OP_BYP_PROG);
        chk(8'h0C, 32'h8, 32'h8);
        op(OP_RESET);
        chk(8'h0C, 32'h2, 32'hF);
        op(OP_BYP_ENTER);
        wr(8'h08, {16'h0, ~w});
        op(OP_BYP_PROG);
        chk(8'h0C, 32'h12, 32'h1F);
        op(OP_BYP_EXIT);
        chk(8'h0C, 32'h2, 32'h1F);
        op(OP_READ);
        chk(8'h14, {16'h0, ~w}, 32'hFFFF);
        $display("bypass test done");
        slow <= 1'b1;
        op(OP_PROGRAM);
        chk(8'h0C, 32'h6, 32'h7);
        $display("poll limit test done");
        op(OP_AUTOSEL);
        chk(8'h0C, 32'h22, 32'h3F);
        op(OP_READ);
        chk(8'h0C, 32'h2A, 32'h3F);
        op(OP_RESET);
        chk(8'h0C, 32'h02, 32'h3F);
        $display("autoselect test done");
        // Low byte FF is never programmed, so the model shows erased data there.
        wr(8'h04, {12'h0, 20'h7F0FF});
        op(OP_SECT_ERASE);
        chk(8'h0C, 32'h182, 32'h1FF);
        op(OP_SUSPEND);
        chk(8'h0C, 32'hC2, 32'h1FF);
        op(OP_RESUME);
        op(OP_SUSPEND);
        chk(8'h0C, 32'hC2, 32'h1FF);
        op(OP_RESUME);
        chk(8'h0C, 32'h82, 32'h1FF);
        op(OP_POLL_ERASE);
        chk(8'h0C, 32'h02, 32'h1FF);
        chk(8'h14, 32'hFFFF, 32'hFFFF);
        op(OP_SUSPEND);
        chk(8'h0C, 32'h08, 32'h08);
        $display("erase test done");
        results();
    end
endmodule : flc_ctrl_tb
